// >>> design/gw_pkg.sv
// constants and message types of the query translator
package gw_pkg;

  // ---------------------------------------------------------------
  // codes on the query side
  // ---------------------------------------------------------------
  localparam logic [7:0]  FN_READ_COILS    = 8'h01;
  localparam logic [7:0]  FN_READ_INPUTS   = 8'h02;
  localparam logic [7:0]  FN_READ_HOLDING  = 8'h03;
  localparam logic [7:0]  FN_READ_INREGS   = 8'h04;
  localparam logic [7:0]  FN_WRITE_COIL    = 8'h05;
  localparam logic [7:0]  FN_WRITE_REG     = 8'h06;
  localparam logic [7:0]  FN_WRITE_COILS   = 8'h0F;
  localparam logic [7:0]  FN_WRITE_REGS    = 8'h10;
  localparam logic [7:0]  FN_ENCAP         = 8'h11;
  localparam logic [7:0]  PARAM_ENC_QUERY  = 8'h01;
  localparam logic [7:0]  PARAM_ENC_REPLY  = 8'h02;

  // ---------------------------------------------------------------
  // codes on the plc network side
  // ---------------------------------------------------------------
  localparam logic [7:0]  OP_PRIO_READ     = 8'h20;
  localparam logic [7:0]  OP_NP_READ       = 8'h00;
  localparam logic [7:0]  OP_PRIO_WRITE    = 8'h1E;
  localparam logic [7:0]  OP_NP_WRITE      = 8'h02;
  localparam logic [7:0]  OP_PRINT         = 8'h22;
  localparam logic [7:0]  OP_PRINT_REPLY   = 8'h92;
  localparam logic [7:0]  SA_COIL_LOW      = 8'h03;
  localparam logic [7:0]  SA_INPUT_LOW     = 8'h05;
  localparam logic [15:0] SA_HOLDING       = 16'h0006;
  localparam logic [15:0] SA_INREGS        = 16'h0009;
  localparam logic [15:0] SA_WRITE_REG     = 16'h000D;
  localparam logic [15:0] SA_WRITE_COILS   = 16'h001F;
  localparam logic [15:0] SA_WRITE_REGS    = 16'h0020;
  localparam logic [15:0] SA_MARKER        = 16'hBAD5;
  localparam logic [7:0]  TN_READ_HOLDING  = 8'h03;
  localparam logic [7:0]  TN_WRITE_COIL    = 8'h05;
  localparam logic [7:0]  TN_WRITE_REG     = 8'h06;
  localparam logic [7:0]  TN_WRITE_COILS   = 8'h0F;
  localparam logic [7:0]  TN_WRITE_REGS    = 8'h10;
  localparam logic [7:0]  MB_ADDR_FILL     = 8'h00;

  // ---------------------------------------------------------------
  // address ranges and layout
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_LOW_FIRST    = 16'h0001;
  localparam logic [15:0] REG_LOW_LAST     = 16'h2000;
  localparam logic [15:0] REG_HIGH_FIRST   = 16'h2001;
  localparam logic [15:0] REG_HIGH_LAST    = 16'h4000;
  localparam logic [15:0] STATUS_OFFSET    = 16'h2000;
  localparam logic [15:0] BITS_PER_REG     = 16'h0010;
  localparam logic [15:0] ONE16            = 16'h0001;
  localparam int          FIFO_DEPTH       = 8;

  // ---------------------------------------------------------------
  // message carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        is_reply;
    logic [7:0]  unit;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] count;
    logic [15:0] value;
  } mb_msg_t;

  typedef struct packed {
    logic        encap;
    logic [7:0]  opcode;
    logic [15:0] status_addr;
    logic [7:0]  transnum;
    logic        status_field;
    logic [15:0] remote;
    logic [15:0] count;
    logic [15:0] mask;
    logic [15:0] data;
    logic        single_coil;
    logic [7:0]  mb_addr;
    logic [7:0]  mb_func;
  } plc_msg_t;

  typedef struct packed {
    logic        is_reply;
    logic [7:0]  opcode;
    logic [15:0] status_addr;
    logic [7:0]  mb_addr;
    logic [15:0] data;
  } plc_rev_t;

  typedef struct packed {
    logic [7:0]  func;
    logic [7:0]  param;
    logic [7:0]  opcode;
    logic [15:0] status_addr;
    logic [15:0] data;
  } mb_encap_t;

endpackage : gw_pkg

// >>> design/msg_fifo.sv
// synchronous valid/ready fifo for translated messages
`timescale 1ns/1ps
module msg_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        do_wr;
  logic        do_rd;

  assign wr_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign rd_valid = (s_q.cnt != '0);
  assign rd_data  = s_q.mem[s_q.rptr];
  assign do_wr    = wr_valid && wr_ready;
  assign do_rd    = rd_valid && rd_ready;

  always_comb begin
    s_d = s_q;
    if (do_wr) begin
      s_d.mem[s_q.wptr] = wr_data;
      s_d.wptr = (s_q.wptr == AW'(DEPTH-1)) ? '0 : s_q.wptr + AW'(1);
    end
    if (do_rd) begin
      s_d.rptr = (s_q.rptr == AW'(DEPTH-1)) ? '0 : s_q.rptr + AW'(1);
    end
    if (do_wr && !do_rd) begin
      s_d.cnt = s_q.cnt + (AW+1)'(1);
    end else if (do_rd && !do_wr) begin
      s_d.cnt = s_q.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_fifo_bound: assert property (@(posedge clk) disable iff (!resetn)
    s_q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");

endmodule : msg_fifo

// >>> design/query_translator.sv
// query to plc-network translator with encapsulation and reverse wrap
// ---------------------------------------------------------------
// Summary of operation
// - read coils becomes priority read, status address M N 03 from bit and count
// - read discrete inputs becomes priority read, status address M N 05
// - read holding registers 1..8192 becomes priority read, status code 0006
// - read holding 8193..16384 becomes non-priority status read, transaction 03
// - read input registers 1..8192 becomes a read with status code 0009
// - write single coil becomes non-priority write, transaction 05, one mask bit
// - write single register 1..8192 becomes priority write, status code 000D
// - write single register 8193..16384 becomes non-priority status write, transaction 06
// - aligned multiple-of-16 coil write becomes priority write, status code 001F
// - coil write inside one register, under 16, becomes masked write, transaction 0F
// - single-coil multiple write is flagged for single-coil reverse translation
// - write multiple registers 1..8192 becomes priority write, status code 0020
// - write multiple registers 8193..16384 becomes non-priority status write, transaction 10
// - register numbers 8193..16384 reach status portion of plc register 1 onward
// - any other query is wrapped in print message with marker BAD5
// - replies to wrapped queries become print replies with marker BAD5
// - wrapped messages carry a zero address byte; received byte is ignored
// - register functions keep the register number as remote address in 1..8192
// - every translatable query is accepted and passed on
// - untranslatable plc messages go out as function 17, parameter 01 or 02
// ---------------------------------------------------------------
`timescale 1ns/1ps
module query_translator #(
  parameter int DEPTH = gw_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              mb_in_valid,
  output logic                   mb_in_ready,
  input  wire gw_pkg::mb_msg_t   mb_in,
  output logic                   plc_out_valid,
  input  wire logic              plc_out_ready,
  output gw_pkg::plc_msg_t       plc_out,
  input  wire logic              rev_in_valid,
  output logic                   rev_in_ready,
  input  wire gw_pkg::plc_rev_t  rev_in,
  output logic                   mb_out_valid,
  input  wire logic              mb_out_ready,
  output gw_pkg::mb_encap_t      mb_out
);
  import gw_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] coil_bit(input logic [15:0] coil);
    logic [15:0] z;
    z = coil - ONE16;
    return z[3:0];
  endfunction : coil_bit

  function automatic logic [15:0] coil_reg(input logic [15:0] coil);
    logic [15:0] z;
    z = coil - ONE16;
    return (z >> 4) + ONE16;
  endfunction : coil_reg

  function automatic logic in_low(input logic [15:0] r);
    return (r >= REG_LOW_FIRST) && (r <= REG_LOW_LAST);
  endfunction : in_low

  function automatic logic in_high(input logic [15:0] r);
    return (r >= REG_HIGH_FIRST) && (r <= REG_HIGH_LAST);
  endfunction : in_high

  function automatic plc_msg_t encap_msg(input mb_msg_t m, input logic [7:0] op);
    plc_msg_t p;
    p             = '0;
    p.encap       = 1'b1;
    p.opcode      = op;
    p.status_addr = SA_MARKER;
    p.mb_addr     = MB_ADDR_FILL;
    p.mb_func     = m.func;
    p.remote      = m.start;
    p.count       = m.count;
    p.data        = m.value;
    return p;
  endfunction : encap_msg

  // ---------------------------------------------------------------
  // translation of one query
  // ---------------------------------------------------------------
  function automatic plc_msg_t translate(input mb_msg_t m);
    plc_msg_t    p;
    logic [3:0]  b;
    logic [16:0] span;
    logic [31:0] ones;
    p    = '0;
    b    = coil_bit(m.start);
    span = {1'b0, 12'h000, b} + {1'b0, m.count};
    ones = (32'h0000_0001 << m.count[4:0]) - 32'h0000_0001;
    p.mb_addr = MB_ADDR_FILL;
    p.mb_func = m.func;
    p.count   = m.count;
    p.data    = m.value;
    if (m.is_reply) begin
      p = encap_msg(m, OP_PRINT_REPLY);
    end else begin
      unique case (m.func)
        FN_READ_COILS: begin
          p.opcode      = OP_PRIO_READ;
          p.status_addr = {b, m.count[3:0], SA_COIL_LOW};
          p.remote      = coil_reg(m.start);
        end
        FN_READ_INPUTS: begin
          p.opcode      = OP_PRIO_READ;
          p.status_addr = {b, m.count[3:0], SA_INPUT_LOW};
          p.remote      = coil_reg(m.start);
        end
        FN_READ_HOLDING: begin
          if (in_low(m.start)) begin
            p.opcode      = OP_PRIO_READ;
            p.status_addr = SA_HOLDING;
            p.remote      = m.start;
          end else if (in_high(m.start)) begin
            p.opcode       = OP_NP_READ;
            p.transnum     = TN_READ_HOLDING;
            p.status_field = 1'b1;
            p.remote       = m.start - STATUS_OFFSET;
          end else begin
            p = encap_msg(m, OP_PRINT);
          end
        end
        FN_READ_INREGS: begin
          if (in_low(m.start)) begin
            p.opcode      = OP_PRIO_READ;
            p.status_addr = SA_INREGS;
            p.remote      = m.start;
          end else begin
            p = encap_msg(m, OP_PRINT);
          end
        end
        FN_WRITE_COIL: begin
          p.opcode   = OP_NP_WRITE;
          p.transnum = TN_WRITE_COIL;
          p.mask     = ONE16 << b;
          p.data     = (m.value != 16'h0000) ? (ONE16 << b) : 16'h0000;
          p.remote   = coil_reg(m.start);
          p.count    = ONE16;
        end
        FN_WRITE_REG: begin
          if (in_low(m.start)) begin
            p.opcode      = OP_PRIO_WRITE;
            p.status_addr = SA_WRITE_REG;
            p.remote      = m.start;
          end else if (in_high(m.start)) begin
            p.opcode       = OP_NP_WRITE;
            p.transnum     = TN_WRITE_REG;
            p.status_field = 1'b1;
            p.remote       = m.start - STATUS_OFFSET;
          end else begin
            p = encap_msg(m, OP_PRINT);
          end
          p.count = ONE16;
        end
        FN_WRITE_COILS: begin
          if (b == 4'h0 && m.count != 16'h0000 && m.count[3:0] == 4'h0) begin
            p.opcode      = OP_PRIO_WRITE;
            p.status_addr = SA_WRITE_COILS;
            p.remote      = coil_reg(m.start);
            p.count       = m.count >> 4;
          end else if (m.count != 16'h0000 && m.count < BITS_PER_REG
                       && span <= {1'b0, BITS_PER_REG}) begin
            p.opcode      = OP_NP_WRITE;
            p.transnum    = TN_WRITE_COILS;
            p.mask        = 16'((ones << b));
            p.data        = 16'((m.value << b)) & 16'((ones << b));
            p.remote      = coil_reg(m.start);
            p.count       = ONE16;
            p.single_coil = (m.count == ONE16);
          end else begin
            p = encap_msg(m, OP_PRINT);
          end
        end
        FN_WRITE_REGS: begin
          if (in_low(m.start)) begin
            p.opcode      = OP_PRIO_WRITE;
            p.status_addr = SA_WRITE_REGS;
            p.remote      = m.start;
          end else if (in_high(m.start)) begin
            p.opcode       = OP_NP_WRITE;
            p.transnum     = TN_WRITE_REGS;
            p.status_field = 1'b1;
            p.remote       = m.start - STATUS_OFFSET;
          end else begin
            p = encap_msg(m, OP_PRINT);
          end
        end
        default: begin
          p = encap_msg(m, OP_PRINT);
        end
      endcase
    end
    return p;
  endfunction : translate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic      stg_v;
    plc_msg_t  stg;
    logic      rev_v;
    mb_encap_t rev;
  } xlate_state_t;

  xlate_state_t s_q;
  xlate_state_t s_d;
  logic         fifo_wr_ready;
  logic         in_fire;
  logic         stg_fire;
  logic         rev_fire;

  // the staging register drains into the fifo; full fifo with an occupied stage stalls the input
  assign stg_fire     = s_q.stg_v && fifo_wr_ready;
  assign mb_in_ready  = !s_q.stg_v || fifo_wr_ready;
  assign in_fire      = mb_in_valid && mb_in_ready;
  assign rev_in_ready = !s_q.rev_v || mb_out_ready;
  assign rev_fire     = rev_in_valid && rev_in_ready;
  assign mb_out_valid = s_q.rev_v;
  assign mb_out       = s_q.rev;

  always_comb begin
    s_d = s_q;
    if (stg_fire) begin
      s_d.stg_v = 1'b0;
    end
    if (in_fire) begin
      s_d.stg_v = 1'b1;
      s_d.stg   = translate(mb_in);
    end
    if (s_q.rev_v && mb_out_ready) begin
      s_d.rev_v = 1'b0;
    end
    if (rev_fire) begin
      s_d.rev_v        = 1'b1;
      s_d.rev.func     = FN_ENCAP;
      s_d.rev.param    = rev_in.is_reply ? PARAM_ENC_REPLY : PARAM_ENC_QUERY;
      s_d.rev.opcode   = rev_in.opcode;
      s_d.rev.status_addr = rev_in.status_addr;
      s_d.rev.data     = rev_in.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  msg_fifo #(
    .W     ($bits(plc_msg_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk      (clk),
    .resetn   (resetn),
    .wr_valid (s_q.stg_v),
    .wr_ready (fifo_wr_ready),
    .wr_data  (s_q.stg),
    .rd_valid (plc_out_valid),
    .rd_ready (plc_out_ready),
    .rd_data  (plc_out)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_coil_read_code: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_READ_COILS |=>
      s_q.stg.opcode == OP_PRIO_READ &&
      s_q.stg.status_addr == {coil_bit($past(mb_in.start)), $past(mb_in.count[3:0]), SA_COIL_LOW})
    else $error("coil read status address wrong");

  a_input_read_code: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_READ_INPUTS |=>
      s_q.stg.status_addr[7:0] == SA_INPUT_LOW && s_q.stg.opcode == OP_PRIO_READ)
    else $error("input read translation wrong");

  a_holding_low: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_READ_HOLDING && in_low(mb_in.start) |=>
      s_q.stg.status_addr == SA_HOLDING && s_q.stg.remote == $past(mb_in.start))
    else $error("holding read low range wrong");

  a_holding_high: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_READ_HOLDING && in_high(mb_in.start) |=>
      s_q.stg.opcode == OP_NP_READ && s_q.stg.transnum == TN_READ_HOLDING &&
      s_q.stg.remote == $past(mb_in.start) - STATUS_OFFSET)
    else $error("holding read status range wrong");

  a_inreg_low: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_READ_INREGS && in_low(mb_in.start) |=>
      s_q.stg.status_addr == SA_INREGS && !s_q.stg.encap)
    else $error("input register read wrong");

  a_single_coil: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_COIL |=>
      s_q.stg.transnum == TN_WRITE_COIL && $onehot(s_q.stg.mask))
    else $error("single coil write mask wrong");

  a_reg_write_low: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_REG && in_low(mb_in.start) |=>
      s_q.stg.opcode == OP_PRIO_WRITE && s_q.stg.status_addr == SA_WRITE_REG)
    else $error("single register write wrong");

  a_regs_write_high: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_REGS && in_high(mb_in.start) |=>
      s_q.stg.status_field && s_q.stg.transnum == TN_WRITE_REGS)
    else $error("multiple register status write wrong");

  a_reg_write_high: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_REG && in_high(mb_in.start) |=>
      s_q.stg.opcode == OP_NP_WRITE && s_q.stg.transnum == TN_WRITE_REG && s_q.stg.status_field)
    else $error("single register status write wrong");

  a_coil_block_write: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_COILS && coil_bit(mb_in.start) == 4'h0 &&
      mb_in.count != 16'h0000 && mb_in.count[3:0] == 4'h0 |=>
      s_q.stg.opcode == OP_PRIO_WRITE && s_q.stg.status_addr == SA_WRITE_COILS)
    else $error("aligned coil write wrong");

  a_coil_mask_write: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_COILS |=>
      s_q.stg.transnum != TN_WRITE_COILS ||
      (s_q.stg.opcode == OP_NP_WRITE && s_q.stg.mask != '0 && !(&s_q.stg.mask)))
    else $error("partial coil write mask wrong");

  a_regs_write_low: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && !mb_in.is_reply && mb_in.func == FN_WRITE_REGS && in_low(mb_in.start) |=>
      s_q.stg.opcode == OP_PRIO_WRITE && s_q.stg.status_addr == SA_WRITE_REGS &&
      s_q.stg.remote == $past(mb_in.start))
    else $error("multiple register write wrong");

  a_encap_marker: assert property (@(posedge clk) disable iff (!resetn)
    s_q.stg_v && s_q.stg.encap |->
      s_q.stg.status_addr == SA_MARKER && s_q.stg.mb_addr == MB_ADDR_FILL &&
      (s_q.stg.opcode == OP_PRINT || s_q.stg.opcode == OP_PRINT_REPLY))
    else $error("encapsulated message lacks marker");

  a_reply_wrap: assert property (@(posedge clk) disable iff (!resetn)
    in_fire && mb_in.is_reply |=> s_q.stg.opcode == OP_PRINT_REPLY)
    else $error("reply not wrapped as print reply");

  a_stage_holds: assert property (@(posedge clk) disable iff (!resetn)
    s_q.stg_v && !fifo_wr_ready |=> s_q.stg_v && $stable(s_q.stg))
    else $error("staged message lost under back-pressure");

  a_rev_wrap: assert property (@(posedge clk) disable iff (!resetn)
    rev_fire |=> mb_out_valid && mb_out.func == FN_ENCAP &&
      mb_out.param == ($past(rev_in.is_reply) ? PARAM_ENC_REPLY : PARAM_ENC_QUERY))
    else $error("reverse wrap code wrong");

endmodule : query_translator

// >>> sim/plc_node.sv
// far-side plc node model: takes translated messages and may stall
`timescale 1ns/1ps
module plc_node
  import gw_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             stall,
  input  wire logic             plc_out_valid,
  input  wire gw_pkg::plc_msg_t plc_out,
  output logic                  plc_out_ready
);
  plc_msg_t got[$];

  // -------------------------------------------------------------
  // acceptance
  // -------------------------------------------------------------
  always @(negedge clk) begin
    plc_out_ready <= resetn && !stall;
  end
  // address byte of wrapped traffic is kept but never interpreted
  always @(posedge clk) begin
    if (resetn && plc_out_valid && plc_out_ready) got.push_back(plc_out);
  end
endmodule : plc_node

// >>> sim/test_query_translator.sv
// self-checking bench of the query translator
`timescale 1ns/1ps
module test_query_translator;
  import gw_pkg::*;
  logic      clk, resetn, stall;
  logic      mb_in_valid, mb_in_ready, plc_out_valid, plc_out_ready;
  logic      rev_in_valid, rev_in_ready, mb_out_valid, mb_out_ready;
  mb_msg_t   mb_in;
  plc_msg_t  plc_out, got;
  plc_rev_t  rev_in;
  mb_encap_t mb_out;
  int        fail_count, n_compared, cyc;

  query_translator #(.DEPTH(8)) i_query_translator (.clk(clk), .resetn(resetn),
    .mb_in_valid(mb_in_valid), .mb_in_ready(mb_in_ready), .mb_in(mb_in),
    .plc_out_valid(plc_out_valid), .plc_out_ready(plc_out_ready), .plc_out(plc_out),
    .rev_in_valid(rev_in_valid), .rev_in_ready(rev_in_ready), .rev_in(rev_in),
    .mb_out_valid(mb_out_valid), .mb_out_ready(mb_out_ready), .mb_out(mb_out));
  plc_node i_plc_node (.clk(clk), .resetn(resetn), .stall(stall), .plc_out_valid(plc_out_valid),
    .plc_out(plc_out), .plc_out_ready(plc_out_ready));

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic send(input logic rep, input logic [7:0] fn, input logic [15:0] st, cnt, val);
    int n;
    n = 0;
    mb_in_valid = 1'b1;
    mb_in = '{rep, 8'h01, fn, st, cnt, val};
    while (!mb_in_ready && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    mb_in_valid = 1'b0;
    @(negedge clk);
  endtask : send

  task automatic pop;
    int n;
    n = 0;
    while (i_plc_node.got.size() == 0 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(32'(i_plc_node.got.size() != 0), 32'h1);
    if (i_plc_node.got.size() != 0) got = i_plc_node.got.pop_front();
  endtask : pop

  // ff in sa or tn means the field is left open
  task automatic xq(input logic [7:0] fn, input logic [15:0] st, cnt, val,
                    input logic [7:0] op, input logic [15:0] sa, input logic [7:0] tn, input logic sf);
    send(1'b0, fn, st, cnt, val);
    pop;
    check(got.opcode, op);
    if (sa != 16'hFFFF) check(got.status_addr, sa);
    if (tn != 8'hFF) check(got.transnum, tn);
    check(got.status_field, sf);
  endtask : xq

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reads;
    xq(8'h01, 16'h0012, 16'h0005, 16'h0000, 8'h20, 16'h1503, 8'hFF, 1'b0);
    check(got.remote, 16'h0002);
    xq(8'h02, 16'h0001, 16'h0010, 16'h0000, 8'h20, 16'h0005, 8'hFF, 1'b0);
    xq(8'h03, 16'h2000, 16'h0002, 16'h0000, 8'h20, 16'h0006, 8'hFF, 1'b0);
    check(got.remote, 16'h2000);
    xq(8'h03, 16'h2001, 16'h0001, 16'h0000, 8'h00, 16'hFFFF, 8'h03, 1'b1);
    check(got.remote, 16'h0001);
    xq(8'h04, 16'h0079, 16'h0001, 16'h0000, 8'h20, 16'h0009, 8'hFF, 1'b0);
    check(got.remote, 16'h0079);
  endtask : t_reads

  task automatic t_writes;
    xq(8'h05, 16'h0003, 16'h0001, 16'hFF00, 8'h02, 16'hFFFF, 8'h05, 1'b0);
    check(got.mask, 16'h0004);
    check(got.data, 16'h0004);
    xq(8'h06, 16'h0064, 16'h0001, 16'h1234, 8'h1E, 16'h000D, 8'hFF, 1'b0);
    check(got.remote, 16'h0064);
    xq(8'h06, 16'h4000, 16'h0001, 16'h1234, 8'h02, 16'hFFFF, 8'h06, 1'b1);
    check(got.remote, 16'h2000);
    xq(8'h0F, 16'h0011, 16'h0020, 16'h0000, 8'h1E, 16'h001F, 8'hFF, 1'b0);
    check({got.remote, got.count}, 32'h0002_0002);
    xq(8'h0F, 16'h0014, 16'h0003, 16'h0005, 8'h02, 16'hFFFF, 8'h0F, 1'b0);
    check(got.mask, 16'h0038);
    check(got.data, 16'h0028);
    check(got.single_coil, 1'b0);
    xq(8'h0F, 16'h0005, 16'h0001, 16'h0001, 8'h02, 16'hFFFF, 8'h0F, 1'b0);
    check(got.single_coil, 1'b1);
    xq(8'h10, 16'h07D0, 16'h0002, 16'h0000, 8'h1E, 16'h0020, 8'hFF, 1'b0);
    check(got.remote, 16'h07D0);
    xq(8'h10, 16'h2FA0, 16'h0002, 16'h0000, 8'h02, 16'hFFFF, 8'h10, 1'b1);
    check(got.remote, 16'h0FA0);
  endtask : t_writes

  task automatic t_encap;
    xq(8'h07, 16'h0005, 16'h0000, 16'h0000, 8'h22, 16'hBAD5, 8'hFF, 1'b0);
    check(got.encap, 1'b1);
    check(got.mb_addr, 8'h00);
    xq(8'h03, 16'h4001, 16'h0001, 16'h0000, 8'h22, 16'hBAD5, 8'hFF, 1'b0);
    send(1'b1, 8'h07, 16'h0005, 16'h0000, 16'h0000);
    pop;
    check({got.opcode, got.status_addr}, 24'h92BAD5);
    check({got.encap, got.mb_addr}, 9'h100);
  endtask : t_encap

  task automatic t_fill;
    stall = 1'b1;
    for (int i = 1; i <= 9; i++) send(1'b0, 8'h03, 16'(i), 16'h0001, 16'h0000);
    check(mb_in_ready, 1'b0);
    check(i_plc_node.got.size(), 0);
    stall = 1'b0;
    send(1'b0, 8'h03, 16'd10, 16'h0001, 16'h0000);
    for (int i = 1; i <= 10; i++) begin
      pop;
      check(got.remote, 16'(i));
    end
  endtask : t_fill

  task automatic t_reverse(input logic rep, input logic [7:0] param);
    mb_out_ready = 1'b0;
    rev_in_valid = 1'b1;
    rev_in = '{rep, 8'h33, 16'h1234, 8'h5A, 16'hBEEF};
    @(negedge clk);
    rev_in_valid = 1'b0;
    check(mb_out_valid, 1'b1);
    check({mb_out.func, mb_out.param}, {8'h11, param});
    check({mb_out.opcode, mb_out.status_addr}, {8'h33, 16'h1234});
    check(mb_out.data, 16'hBEEF);
    @(negedge clk);
    check({mb_out_valid, rev_in_ready}, 2'b10);
    mb_out_ready = 1'b1;
    @(negedge clk);
    check(mb_out_valid, 1'b0);
  endtask : t_reverse

  // -------------------------------------------------------------
  // run control
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[ERR] %0t run exceeded its cycle budget", $time);
      give_verdict;
    end
  end

  initial begin
    resetn = 1'b0;
    stall = 1'b0;
    mb_in_valid = 1'b0;
    mb_in = '0;
    rev_in_valid = 1'b0;
    rev_in = '0;
    mb_out_ready = 1'b1;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    check({plc_out_valid, mb_out_valid, mb_in_ready, rev_in_ready}, 4'h3);
    t_reads;
    t_writes;
    t_encap;
    t_fill;
    t_reverse(1'b0, 8'h01);
    t_reverse(1'b1, 8'h02);
    give_verdict;
  end
endmodule : test_query_translator
